//--- pkg/chan_cfg_pkg.sv
package chan_cfg_pkg;
   // register indices, byte address is four times index
   localparam logic [7:0] IDX_OVH_CFG   = 8'h06;
   localparam logic [7:0] IDX_TIM_CTL   = 8'h07;
   localparam logic [7:0] IDX_CTL_EXT   = 8'h08;
   localparam logic [7:0] IDX_IRQ_ONE   = 8'h0a;
   localparam logic [7:0] IDX_IRQ_TWO   = 8'h0b;
   localparam int         IDX_LSB       = 2;
   // reset values
   localparam logic [7:0] RST_OVH_CFG   = 8'hf1;
   localparam logic [7:0] RST_TIM_CTL   = 8'h00;
   localparam logic [2:0] RST_CTL_EXT   = 3'h0;
   // implemented-bit masks, writable for MSK_TIM_CTL only (unused bits read zero)
   localparam logic [7:0] MSK_TIM_CTL   = 8'hef;
   localparam logic [7:0] MSK_IRQ_ONE   = 8'h7f;
   localparam logic [7:0] MSK_IRQ_TWO   = 8'h1f;
   // overhead config fields
   localparam int B_AUTO_PFEBE = 7;
   localparam int B_AUTO_LFEBE = 6;
   localparam int B_AUTO_LRDI  = 5;
   localparam int B_AUTO_PRDI  = 4;
   localparam int B_PTB_SEL    = 3;
   localparam int B_STB_SEL    = 2;
   localparam int B_Z0_SEL     = 1;
   // timing/loopback fields
   localparam int B_FRAME_EN   = 7;
   localparam int B_RX_INV     = 5;
   localparam int B_PAR_LOOP   = 3;
   localparam int B_LINE_LOOP  = 2;
   localparam int B_SER_LOOP   = 1;
   localparam int B_LOOP_TIM   = 0;
   // overhead byte constants
   localparam logic [7:0] Z0_SECOND     = 8'h02;
   localparam logic [7:0] Z0_THIRD      = 8'h03;
   localparam logic [7:0] J0_NULL       = 8'h00;
endpackage

//--- src/chan_cfg_regs.sv
// Decided for this implementation: the APB register port.
`timescale 1ns/100ps
module chan_cfg_regs
   import chan_cfg_pkg::*;
(
   // clock, reset, enable
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,
   input  wire logic        channel_soft_reset,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic             pslverr,
   output logic [31:0]      prdata,
   // sub-block requests, already gated by their own enables
   input  wire logic        rx_section_irq,
   input  wire logic        rx_line_irq,
   input  wire logic        rx_path_irq,
   input  wire logic        rx_cell_proc_irq,
   input  wire logic        tx_cell_proc_irq,
   input  wire logic        clock_recovery_irq,
   input  wire logic        aps_degrade_irq,
   input  wire logic        path_trace_irq,
   input  wire logic        section_trace_irq,
   input  wire logic        wan_sync_irq,
   input  wire logic        rx_frame_proc_irq,
   input  wire logic        tx_frame_proc_irq,
   // datapath inputs
   input  wire logic [7:0]  z0_prog_value,
   input  wire logic [7:0]  j0_stored_byte,
   input  wire logic [7:0]  j1_stored_byte,
   input  wire logic [7:0]  j1_prog_value,
   input  wire logic        path_alarm_declared,
   input  wire logic        line_alarm_declared,
   input  wire logic        path_bip_err,
   input  wire logic        line_bip_err,
   input  wire logic        synth_tx_clk_tick,
   input  wire logic        recov_rx_clk_tick,
   input  wire logic        tx_serial_bit,
   input  wire logic        rx_serial_bit,
   input  wire logic        rx_recovered_bit,
   input  wire logic        tx_line_bit,
   input  wire logic [7:0]  tx_path_overhead_gen,
   input  wire logic [7:0]  rx_parallel_in,
   input  wire logic        master_frame_pulse,
   input  wire logic        free_frame_pulse,
   // datapath outputs
   output logic [7:0]       z0_byte_second,
   output logic [7:0]       z0_byte_third,
   output logic [7:0]       j0_tx_byte,
   output logic [7:0]       j1_tx_byte,
   output logic             path_rdi_insert,
   output logic             line_rdi_insert,
   output logic             path_febe_pulse,
   output logic             line_febe_pulse,
   output logic             tx_clk_tick,
   output logic             rx_serial_sel,
   output logic             tx_serial_out,
   output logic [7:0]       rx_path_overhead_proc,
   output logic             rx_pos_active_high,
   output logic             tx_frame_pulse,
   output logic [2:0]       ctl_ext_bits,
   output logic             channel_one_irq
);

   logic [7:0] ovh_cfg_r;
   logic [7:0] tim_ctl_r;
   logic [2:0] ctl_ext_r;
   logic [7:0] irq_one_r;
   logic [7:0] irq_two_r;
   logic [7:0] irq_one_nxt;
   logic [7:0] irq_two_nxt;
   logic [7:0] rd_byte;
   logic [7:0] idx;
   logic       wr_en;
   logic       mapped;

   // register index from a byte address
   function automatic logic [7:0] reg_index(input logic [11:0] a);
      reg_index = a[IDX_LSB+7:IDX_LSB];
   endfunction

   assign idx     = reg_index(paddr);
   assign mapped  = (idx == IDX_OVH_CFG) || (idx == IDX_TIM_CTL) || (idx == IDX_CTL_EXT)
                 || (idx == IDX_IRQ_ONE) || (idx == IDX_IRQ_TWO);
   // zero-wait slave; writes to read-only or unmapped words are ignored
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign wr_en   = psel & penable & pwrite & mapped & clk_en;

   // configuration registers; soft reset holds them at defaults
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovh_cfg_r <= RST_OVH_CFG;
         tim_ctl_r <= RST_TIM_CTL;
         ctl_ext_r <= RST_CTL_EXT;
      end else if (clk_en) begin
         if (channel_soft_reset) begin
            ovh_cfg_r <= RST_OVH_CFG;
            tim_ctl_r <= RST_TIM_CTL;
            ctl_ext_r <= RST_CTL_EXT;
         end else if (wr_en) begin
            if (idx == IDX_OVH_CFG) ovh_cfg_r <= pwdata[7:0];
            if (idx == IDX_TIM_CTL) tim_ctl_r <= pwdata[7:0] & MSK_TIM_CTL;
            if (idx == IDX_CTL_EXT) ctl_ext_r <= pwdata[2:0];
         end
      end
   end

   // summary bits mirror sub-block requests; no clear here
   always_comb begin
      irq_one_nxt = {1'b0, aps_degrade_irq, clock_recovery_irq, tx_cell_proc_irq,
                     rx_cell_proc_irq, rx_path_irq, rx_line_irq, rx_section_irq};
      irq_two_nxt = {3'b000, tx_frame_proc_irq, rx_frame_proc_irq, wan_sync_irq,
                     section_trace_irq, path_trace_irq};
   end

   // sampled once so a read sees a stable value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_one_r <= 8'h00;
         irq_two_r <= 8'h00;
      end else if (clk_en) begin
         if (channel_soft_reset) begin
            irq_one_r <= 8'h00;
            irq_two_r <= 8'h00;
         end else begin
            irq_one_r <= irq_one_nxt & MSK_IRQ_ONE;
            irq_two_r <= irq_two_nxt & MSK_IRQ_TWO;
         end
      end
   end

   // channel request for the global status
   assign channel_one_irq = (|irq_one_r) | (|irq_two_r);

   // read mux
   always_comb begin
      case (idx)
         IDX_OVH_CFG: rd_byte = ovh_cfg_r;
         IDX_TIM_CTL: rd_byte = tim_ctl_r;
         IDX_CTL_EXT: rd_byte = {5'h00, ctl_ext_r};
         IDX_IRQ_ONE: rd_byte = irq_one_r;
         IDX_IRQ_TWO: rd_byte = irq_two_r;
         default:     rd_byte = 8'h00;
      endcase
   end

   // read data registered during setup so it is valid in access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata <= 32'h0000_0000;
      else if (clk_en && psel && !penable && !pwrite) prdata <= {24'h000000, rd_byte};
   end

   // overhead byte selection, registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         z0_byte_second <= Z0_SECOND;
         z0_byte_third  <= Z0_THIRD;
         j0_tx_byte     <= J0_NULL;
         j1_tx_byte     <= 8'h00;
      end else if (clk_en) begin
         z0_byte_second <= ovh_cfg_r[B_Z0_SEL] ? z0_prog_value : Z0_SECOND;
         z0_byte_third  <= ovh_cfg_r[B_Z0_SEL] ? z0_prog_value : Z0_THIRD;
         j0_tx_byte     <= ovh_cfg_r[B_STB_SEL] ? j0_stored_byte : J0_NULL;
         j1_tx_byte     <= ovh_cfg_r[B_PTB_SEL] ? j1_stored_byte : j1_prog_value;
      end
   end

   // rdi and febe: one febe per bip error event, same cycle count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         path_rdi_insert <= 1'b0;
         line_rdi_insert <= 1'b0;
         path_febe_pulse <= 1'b0;
         line_febe_pulse <= 1'b0;
      end else if (clk_en) begin
         path_rdi_insert <= ovh_cfg_r[B_AUTO_PRDI] & path_alarm_declared;
         line_rdi_insert <= ovh_cfg_r[B_AUTO_LRDI] & line_alarm_declared;
         path_febe_pulse <= ovh_cfg_r[B_AUTO_PFEBE] & path_bip_err;
         line_febe_pulse <= ovh_cfg_r[B_AUTO_LFEBE] & line_bip_err;
      end
   end

   // timing, loopback and polarity steering
   // both serial loopbacks at once is illegal; each path still follows its own bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_clk_tick           <= 1'b0;
         rx_serial_sel         <= 1'b0;
         tx_serial_out         <= 1'b0;
         rx_path_overhead_proc <= 8'h00;
         rx_pos_active_high    <= 1'b1;
         tx_frame_pulse        <= 1'b0;
      end else if (clk_en) begin
         tx_clk_tick <= tim_ctl_r[B_LOOP_TIM] ? recov_rx_clk_tick
                                              : synth_tx_clk_tick;
         rx_serial_sel <= tim_ctl_r[B_SER_LOOP] ? tx_serial_bit : rx_serial_bit;
         tx_serial_out <= tim_ctl_r[B_LINE_LOOP] ? rx_recovered_bit : tx_line_bit;
         rx_path_overhead_proc <= tim_ctl_r[B_PAR_LOOP] ? tx_path_overhead_gen
                                                        : rx_parallel_in;
         rx_pos_active_high <= ~tim_ctl_r[B_RX_INV];
         tx_frame_pulse <= tim_ctl_r[B_FRAME_EN] ? master_frame_pulse
                                                 : free_frame_pulse;
      end
   end

   assign ctl_ext_bits = ctl_ext_r; // reserved, kept at default by software

   // assertions
   property p_z0_default;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && !ovh_cfg_r[B_Z0_SEL]) |=> (z0_byte_second == Z0_SECOND && z0_byte_third == Z0_THIRD);
   endproperty
   a_z0_default: assert property (p_z0_default) else $error("z0 default bytes wrong");

   property p_j0_null;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && !ovh_cfg_r[B_STB_SEL]) |=> (j0_tx_byte == J0_NULL);
   endproperty
   a_j0_null: assert property (p_j0_null) else $error("j0 not null");

   property p_j1_sel;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && ovh_cfg_r[B_PTB_SEL]) |=> (j1_tx_byte == $past(j1_stored_byte));
   endproperty
   a_j1_sel: assert property (p_j1_sel) else $error("j1 stored byte not sent");

   property p_path_febe;
      @(posedge pclk) disable iff (!presetn)
      clk_en |=> (path_febe_pulse == ($past(path_bip_err) && $past(ovh_cfg_r[B_AUTO_PFEBE])));
   endproperty
   a_path_febe: assert property (p_path_febe) else $error("path febe mismatch");

   property p_line_febe;
      @(posedge pclk) disable iff (!presetn)
      clk_en |=> (line_febe_pulse == ($past(line_bip_err) && $past(ovh_cfg_r[B_AUTO_LFEBE])));
   endproperty
   a_line_febe: assert property (p_line_febe) else $error("line febe mismatch");

   property p_path_rdi;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && ovh_cfg_r[B_AUTO_PRDI] && path_alarm_declared) |=> path_rdi_insert;
   endproperty
   a_path_rdi: assert property (p_path_rdi) else $error("path rdi missing");

   property p_line_rdi;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && ovh_cfg_r[B_AUTO_LRDI] && line_alarm_declared) |=> line_rdi_insert;
   endproperty
   a_line_rdi: assert property (p_line_rdi) else $error("line rdi missing");

   property p_soft_reset;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && channel_soft_reset) |=> (ovh_cfg_r == RST_OVH_CFG && tim_ctl_r == RST_TIM_CTL);
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset not applied");

   property p_irq_or;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && !channel_soft_reset && (rx_section_irq || tx_frame_proc_irq))
         |=> channel_one_irq;
   endproperty
   a_irq_or: assert property (p_irq_or) else $error("channel irq not raised");

   property p_loop_timing;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && tim_ctl_r[B_LOOP_TIM]) |=> (tx_clk_tick == $past(recov_rx_clk_tick));
   endproperty
   a_loop_timing: assert property (p_loop_timing) else $error("loop timing wrong");

   property p_z0_prog;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && ovh_cfg_r[B_Z0_SEL]) |=> (z0_byte_second == $past(z0_prog_value)
                                           && z0_byte_third == $past(z0_prog_value));
   endproperty
   a_z0_prog: assert property (p_z0_prog) else $error("z0 programmed bytes wrong");

   property p_j0_stored;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && ovh_cfg_r[B_STB_SEL]) |=> (j0_tx_byte == $past(j0_stored_byte));
   endproperty
   a_j0_stored: assert property (p_j0_stored) else $error("j0 stored byte not sent");

   // presetn in the antecedent skips the edge that releases reset
   property p_j1_prog;
      @(posedge pclk) disable iff (!presetn)
      (presetn && clk_en && !ovh_cfg_r[B_PTB_SEL]) |=> (j1_tx_byte == $past(j1_prog_value));
   endproperty
   a_j1_prog: assert property (p_j1_prog) else $error("j1 programmed byte not sent");

   property p_path_rdi_off;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && !ovh_cfg_r[B_AUTO_PRDI]) |=> !path_rdi_insert;
   endproperty
   a_path_rdi_off: assert property (p_path_rdi_off) else $error("path rdi unasked");

   property p_line_rdi_off;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && !ovh_cfg_r[B_AUTO_LRDI]) |=> !line_rdi_insert;
   endproperty
   a_line_rdi_off: assert property (p_line_rdi_off) else $error("line rdi unasked");

   property p_self_timed;
      @(posedge pclk) disable iff (!presetn)
      (presetn && clk_en && !tim_ctl_r[B_LOOP_TIM])
         |=> (tx_clk_tick == $past(synth_tx_clk_tick));
   endproperty
   a_self_timed: assert property (p_self_timed) else $error("self timing wrong");

   property p_ser_loop;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && tim_ctl_r[B_SER_LOOP]) |=> (rx_serial_sel == $past(tx_serial_bit));
   endproperty
   a_ser_loop: assert property (p_ser_loop) else $error("serial loopback wrong");

   property p_ser_norm;
      @(posedge pclk) disable iff (!presetn)
      (presetn && clk_en && !tim_ctl_r[B_SER_LOOP])
         |=> (rx_serial_sel == $past(rx_serial_bit));
   endproperty
   a_ser_norm: assert property (p_ser_norm) else $error("rx serial path wrong");

   property p_line_loop;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && tim_ctl_r[B_LINE_LOOP]) |=> (tx_serial_out == $past(rx_recovered_bit));
   endproperty
   a_line_loop: assert property (p_line_loop) else $error("line loopback wrong");

   property p_line_norm;
      @(posedge pclk) disable iff (!presetn)
      (presetn && clk_en && !tim_ctl_r[B_LINE_LOOP])
         |=> (tx_serial_out == $past(tx_line_bit));
   endproperty
   a_line_norm: assert property (p_line_norm) else $error("tx serial path wrong");

   property p_par_loop;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && tim_ctl_r[B_PAR_LOOP])
         |=> (rx_path_overhead_proc == $past(tx_path_overhead_gen));
   endproperty
   a_par_loop: assert property (p_par_loop) else $error("parallel loopback wrong");

   property p_rx_polarity;
      @(posedge pclk) disable iff (!presetn)
      clk_en |=> (rx_pos_active_high == !$past(tim_ctl_r[B_RX_INV]));
   endproperty
   a_rx_polarity: assert property (p_rx_polarity) else $error("rx polarity wrong");

   property p_frame_align;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && tim_ctl_r[B_FRAME_EN]) |=> (tx_frame_pulse == $past(master_frame_pulse));
   endproperty
   a_frame_align: assert property (p_frame_align) else $error("frame align wrong");

   property p_irq_one_map;
      @(posedge pclk) disable iff (!presetn)
      (presetn && clk_en && !channel_soft_reset)
         |=> (irq_one_r == {1'b0, $past(aps_degrade_irq), $past(clock_recovery_irq),
                            $past(tx_cell_proc_irq), $past(rx_cell_proc_irq),
                            $past(rx_path_irq), $past(rx_line_irq), $past(rx_section_irq)});
   endproperty
   a_irq_one_map: assert property (p_irq_one_map) else $error("summary one wrong");

   property p_irq_two_map;
      @(posedge pclk) disable iff (!presetn)
      (presetn && clk_en && !channel_soft_reset)
         |=> (irq_two_r == {3'b000, $past(tx_frame_proc_irq),
                            $past(rx_frame_proc_irq), $past(wan_sync_irq),
                            $past(section_trace_irq), $past(path_trace_irq)});
   endproperty
   a_irq_two_map: assert property (p_irq_two_map) else $error("summary two wrong");

   property p_srst_irq;
      @(posedge pclk) disable iff (!presetn)
      (clk_en && channel_soft_reset) |=> !channel_one_irq;
   endproperty
   a_srst_irq: assert property (p_srst_irq) else $error("summary kept in reset");

   c_febe: cover property (@(posedge pclk) disable iff (!presetn) path_febe_pulse);
   c_loop: cover property (@(posedge pclk) disable iff (!presetn) tim_ctl_r[B_LINE_LOOP]);
   c_par:  cover property (@(posedge pclk) disable iff (!presetn) tim_ctl_r[B_PAR_LOOP]);
   c_irq:  cover property (@(posedge pclk) disable iff (!presetn) channel_one_irq);
   c_srst: cover property (@(posedge pclk) disable iff (!presetn) channel_soft_reset);

endmodule

//--- sim/tb_chan_cfg_regs.sv
`timescale 1ns/100ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
   $display("MISMATCH %0t got %0h exp %0h", $time, g, e); end end
module tb_chan_cfg_regs;
   import chan_cfg_pkg::*;
   logic        pclk, presetn, clk_en, channel_soft_reset;
   logic        psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr, irq;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0]  z0p, j0s, j1s, j1p, poh, rpar, z0b2, z0b3, j0b, j1b, rpoh, misc;
   logic [3:0]  alm;
   logic        prdi, lrdi, pfebe, lfebe, tick, rsel, tser, rpos, tfp, irq_out;
   logic [2:0]  ext;
   int          mismatches, checks, cycles, pf, lf;

   chan_cfg_regs u_chan_cfg_regs (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
      .channel_soft_reset(channel_soft_reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .pslverr(pslverr), .prdata(prdata), .rx_section_irq(irq[0]), .rx_line_irq(irq[1]),
      .rx_path_irq(irq[2]), .rx_cell_proc_irq(irq[3]), .tx_cell_proc_irq(irq[4]),
      .clock_recovery_irq(irq[5]), .aps_degrade_irq(irq[6]), .path_trace_irq(irq[7]),
      .section_trace_irq(irq[8]), .wan_sync_irq(irq[9]), .rx_frame_proc_irq(irq[10]),
      .tx_frame_proc_irq(irq[11]), .z0_prog_value(z0p), .j0_stored_byte(j0s),
      .j1_stored_byte(j1s), .j1_prog_value(j1p), .path_alarm_declared(alm[0]),
      .line_alarm_declared(alm[1]), .path_bip_err(alm[2]), .line_bip_err(alm[3]),
      .synth_tx_clk_tick(misc[0]), .recov_rx_clk_tick(misc[1]), .tx_serial_bit(misc[2]),
      .rx_serial_bit(misc[3]), .rx_recovered_bit(misc[4]), .tx_line_bit(misc[5]),
      .tx_path_overhead_gen(poh), .rx_parallel_in(rpar), .master_frame_pulse(misc[6]),
      .free_frame_pulse(misc[7]), .z0_byte_second(z0b2), .z0_byte_third(z0b3),
      .j0_tx_byte(j0b), .j1_tx_byte(j1b), .path_rdi_insert(prdi), .line_rdi_insert(lrdi),
      .path_febe_pulse(pfebe), .line_febe_pulse(lfebe), .tx_clk_tick(tick),
      .rx_serial_sel(rsel), .tx_serial_out(tser), .rx_path_overhead_proc(rpoh),
      .rx_pos_active_high(rpos), .tx_frame_pulse(tfp), .ctl_ext_bits(ext),
      .channel_one_irq(irq_out));

   // free-running clock and a hang limit well above the expected run
   initial begin
      pclk = 0;
      forever #2 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         finish_test();
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // one apb transfer; request held until pready is seen at an edge
   // only the bench timeout ends a wait for pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      apb(0, a, 0);
      `CHK(rd, e)
   endtask

   task automatic t_reset();
      rchk(12'h018, {24'h0, RST_OVH_CFG});
      rchk(12'h01c, 32'h0);
      rchk(12'h020, 32'h0);
      `CHK({z0b2, z0b3, j0b, rpos}, {Z0_SECOND, Z0_THIRD, J0_NULL, 1'b1})
      `CHK(ext, RST_CTL_EXT)
      $display("reset test done");
   endtask

   // febe pulses are counted over a window holding three bip cycles
   task automatic bip_burst();
      pf = 0; lf = 0;
      for (int i = 0; i < 14; i++) begin
         @(posedge pclk);
         alm[3:2] <= (i % 4 == 0 && i < 12) ? 2'b11 : 2'b00;
         pf += pfebe; lf += lfebe;
      end
   endtask

   task automatic t_ovh();
      apb(1, 12'h018, 32'h0f);
      rchk(12'h018, 32'h0f);
      alm[1:0] <= 2'b11;
      bip_burst();
      `CHK({z0b2, z0b3, j0b, j1b}, {z0p, z0p, j0s, j1s})
      `CHK({prdi, lrdi, pf[3:0], lf[3:0]}, 10'h0)
      apb(1, 12'h018, 32'hf1);
      bip_burst();
      `CHK({z0b2, z0b3, j0b, j1b}, {Z0_SECOND, Z0_THIRD, J0_NULL, j1p})
      `CHK({prdi, lrdi, pf[3:0], lf[3:0]}, 10'h333)
      alm[1:0] <= 2'b00;
      $display("overhead test done");
   endtask

   // legal combinations only: never both serial loopbacks
   // no alignment with loop timing or line loopback
   // reserved bit six stays at its default
   task automatic t_tim();
      logic [7:0] vals[3] = '{8'h2b, 8'h90, 8'h04};
      foreach (vals[k]) begin
         apb(1, 12'h01c, {24'hffffff, vals[k]});
         rchk(12'h01c, {24'h0, vals[k] & MSK_TIM_CTL});
         cyc(2);
         `CHK(tick, vals[k][0] ? misc[1] : misc[0])
         `CHK(rsel, vals[k][1] ? misc[2] : misc[3])
         `CHK(tser, vals[k][2] ? misc[4] : misc[5])
         `CHK(rpoh, vals[k][3] ? poh : rpar)
         `CHK(rpos, !vals[k][5])
         `CHK(tfp, vals[k][7] ? misc[6] : misc[7])
      end
      apb(1, 12'h01c, 32'h0);
      $display("timing test done");
   endtask

   task automatic t_irq();
      for (int i = 0; i < 12; i++) begin
         irq <= 12'h1 << i;
         apb(1, 12'h028, 32'hff);
         `CHK(err, 1'b0)
         rchk(12'h028, i < 7 ? 32'h1 << i : 32'h0);
         rchk(12'h02c, i < 7 ? 32'h0 : 32'h1 << (i - 7));
         `CHK(irq_out, 1'b1)
      end
      irq <= 0;
      cyc(3);
      `CHK(irq_out, 1'b0)
      $display("summary test done");
   endtask

   task automatic t_err();
      rchk(12'h024, 32'h0);
      `CHK(err, 1'b1)
      apb(1, 12'h004, 32'h55);
      `CHK(err, 1'b1)
      clk_en <= 0;
      apb(1, 12'h018, 32'h0f);
      clk_en <= 1;
      rchk(12'h018, 32'hf1);
      apb(1, 12'h018, 32'h0f);
      channel_soft_reset <= 1;
      cyc(3);
      channel_soft_reset <= 0;
      rchk(12'h018, 32'hf1);
      `CHK(z0b2, Z0_SECOND)
      $display("error and reset test done");
   endtask

   task automatic finish_test();
      $display("mismatches %0d checks %0d", mismatches, checks);
      if (mismatches == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // inputs idle at time zero, reset held for eight cycles
   initial begin
      {presetn, channel_soft_reset, psel, penable, pwrite, paddr, pwdata} = '0;
      clk_en = 1; irq = 0; alm = 0; misc = 8'h56;
      z0p = 8'h5a; j0s = 8'hc3; j1s = 8'h3c; j1p = 8'ha5; poh = 8'h77; rpar = 8'h88;
      mismatches = 0; checks = 0; cycles = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1;
      t_reset();
      t_ovh();
      t_tim();
      t_irq();
      t_err();
      finish_test();
   end
endmodule
